// file: rtl/nvm_access_map.svh
// Register offsets, field positions, reset values and timing counts of the
// data EEPROM access block.
// Assumes inclusion by bare name from design and bench files.
`ifndef NVM_ACCESS_MAP_SVH
`define NVM_ACCESS_MAP_SVH

// Byte depth of the array; addresses run from zero to depth minus one.
`define NVM_DEPTH           256
`define NVM_ADDR_MASK       8'hFF

// Bank zero locations seen by the processor core.
`define ADDR_INDIRECT_ONE   8'h00
`define ADDR_POINTER_ONE    8'h01
`define ADDR_BANK_SELECT    8'h04
`define ADDR_IRQ_CTRL       8'h10
`define ADDR_NVM_ADDRESS    8'h2A
`define ADDR_NVM_DATA       8'h2B

// The control register sits behind the indirect pointer in bank one.
`define NVM_CTRL_PTR        8'h40
`define NVM_CTRL_BANK       8'h01

// Control register fields.
`define CTRL_READ_TRIG      0
`define CTRL_READ_PERM      1
`define CTRL_PROG_TRIG      2
`define CTRL_PROG_PERM      3

// Interrupt register fields.
`define IRQ_NVM_ENABLE      0
`define IRQ_NVM_FLAG        1
`define IRQ_MF_ENABLE       2
`define IRQ_MF_FLAG         3

// Reset values.
`define NVM_CTRL_RESET      4'h0
`define BANK_SEL_RESET      8'h00

// Read cycle length in system clocks; program length in timer ticks.
`define NVM_READ_CYCLES     2'h2
`define NVM_PROG_TICKS      16'h0008

`endif

// file: rtl/nvm_pkg.sv
// Types shared by the data EEPROM access block.
// Assumes nothing of its surroundings.
package nvm_pkg;

	typedef enum logic [1:0] {
		IDLE = 2'b00,
		READ = 2'b01,
		PROG = 2'b10
	} nvm_state_t;

	typedef struct packed {
		nvm_state_t  state;
		logic [7:0]  bankSel;
		logic [7:0]  pointerOne;
		logic [7:0]  nvmAddr;
		logic [7:0]  nvmData;
		logic [7:0]  latchAddr;
		logic [7:0]  latchData;
		logic        progPerm;
		logic        progTrig;
		logic        readPerm;
		logic        readTrig;
		logic        nvmIrqEn;
		logic        nvmIrqFlag;
		logic        mfIrqEn;
		logic        mfIrqFlag;
		logic        irqReq;
		logic [7:0]  cpuRdata;
		logic [15:0] tickCnt;
		logic [1:0]  readCnt;
		logic        memRd;
		logic        memWr;
	} ctrl_regs_t;

endpackage

// file: rtl/nvm_port_if.sv
// Connection between the access controller and the byte array.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface nvm_port_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       read_permission;
	logic       program_permission;

	modport ctrl (output addr, output wdata, output read_permission, output program_permission,
		input rdata);
	modport mem (input addr, input wdata, input read_permission, input program_permission,
		output rdata);
endinterface

// file: rtl/nvm_array.sv
// Byte-wide nonvolatile array model with registered read data.
// Assumes strobes from the controller are single-cycle pulses.
`timescale 1ns/1ns
`include "nvm_access_map.svh"
module nvm_array (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// Controller side.
	nvm_port_if.mem   port
);

	logic [7:0] cells [0:`NVM_DEPTH-1];
	logic [7:0] rdata_q;

	always_ff @(posedge sys_clk) begin
		if (port.program_permission) begin
			cells[port.addr & `NVM_ADDR_MASK] <= port.wdata;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else if (port.read_permission) begin
			rdata_q <= cells[port.addr & `NVM_ADDR_MASK];
		end
	end

	assign port.rdata = rdata_q;

endmodule

// file: rtl/nvm_access.sv
// Data EEPROM access controller: address, data and control registers,
// read and program sequencing, and the end-of-program interrupt flags.
// Assumes the core presents synchronous single-cycle read and write strobes
// and a program timer tick that is already in the system clock domain.
`timescale 1ns/1ns
`include "nvm_access_map.svh"

// Functional notes
// - Byte array from zero to its depth minus one, here 256 bytes.
// - Each access moves one byte via address, data and control registers.
// - Program permission must be set; without it programs never start.
// - Program trigger starts a program; hardware clears it when done.
// - Program request without permission is ignored.
// - Read permission must be set; without it reads never start.
// - Read trigger starts a read; hardware clears it when done.
// - Read request without permission is ignored.
// - Read byte lands in data register and stays until next read or data write.
// - Program length is set by a timer apart from the system clock.
// - Program permission clears at power-on.
// - Bank select resets to zero at power-on.
// - Program end sets the array flag and the shared flag together.
// - Interrupt taken only with global, array and shared enables set.
// - Service clears only the shared flag; software clears the other.
// - Control bits 7..4 read zero; bits 3..0 reset to zero.
module nvm_access (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// Processor data memory access.
	input  wire logic [7:0] cpuAddr,
	input  wire logic       cpuWrite,
	input  wire logic       cpuRead,
	input  wire logic [7:0] cpuWdata,
	output logic      [7:0] cpuRdata,
	// Program timer.
	input  wire logic       progTick,
	// Interrupt controller.
	input  wire logic       globalIrqEnable,
	input  wire logic       irqAck,
	output logic            irqRequest
);

	nvm_pkg::ctrl_regs_t r;
	nvm_pkg::ctrl_regs_t n;

	logic       ctrlSelected;
	logic       ctrlWrite;
	logic       ctrlRead;
	logic       startRead;
	logic       startProg;
	logic       readDone;
	logic       progDone;
	logic       irqWrite;
	logic [7:0] ctrlValue;
	logic [7:0] irqValue;

	nvm_port_if port ();

	nvm_array u_array (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.port    (port.mem)
	);

	assign port.addr  = r.latchAddr;
	assign port.wdata = r.latchData;
	assign port.read_permission  = r.memRd;
	assign port.program_permission  = r.memWr;

	assign cpuRdata   = r.cpuRdata;
	assign irqRequest = r.irqReq;

	always_comb begin
		n = r;
		n.memRd = 1'b0;
		n.memWr = 1'b0;

		// The control register answers only through the indirect window.
		ctrlSelected = (r.pointerOne == `NVM_CTRL_PTR) &&
			(r.bankSel == `NVM_CTRL_BANK);
		ctrlWrite = cpuWrite && (cpuAddr == `ADDR_INDIRECT_ONE) &&
			ctrlSelected;
		ctrlRead  = cpuRead && (cpuAddr == `ADDR_INDIRECT_ONE) &&
			ctrlSelected;
		irqWrite  = cpuWrite && (cpuAddr == `ADDR_IRQ_CTRL);

		// Triggers start a cycle only from idle and with permission already
		// set; a request naming both cycles starts neither.
		startProg = ctrlWrite && (r.state == nvm_pkg::IDLE) &&
			cpuWdata[`CTRL_PROG_TRIG] && r.progPerm &&
			!cpuWdata[`CTRL_READ_TRIG];
		startRead = ctrlWrite && (r.state == nvm_pkg::IDLE) &&
			cpuWdata[`CTRL_READ_TRIG] && r.readPerm &&
			!cpuWdata[`CTRL_PROG_TRIG];

		readDone = (r.state == nvm_pkg::READ) &&
			(r.readCnt == `NVM_READ_CYCLES - 2'h1);
		progDone = (r.state == nvm_pkg::PROG) && progTick &&
			(r.tickCnt == `NVM_PROG_TICKS - 16'h0001);

		ctrlValue = {4'h0, r.progPerm, r.progTrig, r.readPerm,
			r.readTrig};
		irqValue  = {4'h0, r.mfIrqFlag, r.mfIrqEn, r.nvmIrqFlag,
			r.nvmIrqEn};

		// Plain register writes in bank zero.
		if (cpuWrite) begin
			unique case (cpuAddr)
				`ADDR_POINTER_ONE: begin
					n.pointerOne = cpuWdata;
				end
				`ADDR_BANK_SELECT: begin
					n.bankSel = cpuWdata;
				end
				`ADDR_NVM_ADDRESS: begin
					n.nvmAddr = cpuWdata & `NVM_ADDR_MASK;
				end
				`ADDR_NVM_DATA: begin
					n.nvmData = cpuWdata;
				end
				default: begin
				end
			endcase
		end

		// Permissions follow every control write; triggers are left to the
		// sequencer below.
		if (ctrlWrite) begin
			n.progPerm = cpuWdata[`CTRL_PROG_PERM];
			n.readPerm = cpuWdata[`CTRL_READ_PERM];
		end

		unique case (r.state)
			nvm_pkg::IDLE: begin
				if (startProg) begin
					n.state     = nvm_pkg::PROG;
					n.progTrig  = 1'b1;
					n.tickCnt   = 16'h0000;
					n.latchAddr = r.nvmAddr;
					n.latchData = r.nvmData;
				end else if (startRead) begin
					n.state     = nvm_pkg::READ;
					n.readTrig  = 1'b1;
					n.readCnt   = 2'h0;
					n.latchAddr = r.nvmAddr;
					n.memRd     = 1'b1;
				end
			end
			nvm_pkg::READ: begin
				n.readCnt = r.readCnt + 2'h1;
				if (readDone) begin
					n.state    = nvm_pkg::IDLE;
					n.readTrig = 1'b0;
					n.nvmData  = port.rdata;
				end
			end
			nvm_pkg::PROG: begin
				if (progTick) begin
					n.tickCnt = r.tickCnt + 16'h0001;
				end
				if (progDone) begin
					n.state    = nvm_pkg::IDLE;
					n.progTrig = 1'b0;
					n.memWr    = 1'b1;
				end
			end
			default: begin
				n.state = nvm_pkg::IDLE;
			end
		endcase

		// Interrupt register: enables are plain bits, flags clear on a write
		// of zero, and a program end in the same cycle wins over the clear.
		if (irqWrite) begin
			n.nvmIrqEn   = cpuWdata[`IRQ_NVM_ENABLE];
			n.mfIrqEn    = cpuWdata[`IRQ_MF_ENABLE];
			n.nvmIrqFlag = cpuWdata[`IRQ_NVM_FLAG];
			n.mfIrqFlag  = cpuWdata[`IRQ_MF_FLAG];
		end
		if (irqAck) begin
			n.mfIrqFlag = 1'b0;
		end
		if (progDone) begin
			n.nvmIrqFlag = 1'b1;
			n.mfIrqFlag  = 1'b1;
		end
		n.irqReq = globalIrqEnable && n.nvmIrqEn && n.mfIrqEn &&
			n.nvmIrqFlag && n.mfIrqFlag;

		// Read data is returned on the edge after the read strobe.
		n.cpuRdata = 8'h00;
		if (cpuRead) begin
			unique case (cpuAddr)
				`ADDR_INDIRECT_ONE: begin
					n.cpuRdata = ctrlSelected ? ctrlValue : 8'h00;
				end
				`ADDR_POINTER_ONE: begin
					n.cpuRdata = r.pointerOne;
				end
				`ADDR_BANK_SELECT: begin
					n.cpuRdata = r.bankSel;
				end
				`ADDR_IRQ_CTRL: begin
					n.cpuRdata = irqValue;
				end
				`ADDR_NVM_ADDRESS: begin
					n.cpuRdata = r.nvmAddr;
				end
				`ADDR_NVM_DATA: begin
					n.cpuRdata = r.nvmData;
				end
				default: begin
					n.cpuRdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			r.bankSel <= `BANK_SEL_RESET;
			{r.progPerm, r.progTrig, r.readPerm, r.readTrig} <=
				`NVM_CTRL_RESET;
		end else begin
			r <= n;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	prog_refused_a: assert property (
		(ctrlWrite && cpuWdata[`CTRL_PROG_TRIG] && !r.progPerm &&
			r.state == nvm_pkg::IDLE)
		|=> (r.state != nvm_pkg::PROG) && !r.progTrig)
		else $error("Program started without permission.");

	read_refused_a: assert property (
		(ctrlWrite && cpuWdata[`CTRL_READ_TRIG] && !r.readPerm &&
			r.state == nvm_pkg::IDLE)
		|=> (r.state != nvm_pkg::READ) && !r.readTrig)
		else $error("Read started without permission.");

	read_length_a: assert property (
		startRead |=> r.readTrig ##1 r.readTrig
		##1 (!r.readTrig && r.state == nvm_pkg::IDLE))
		else $error("Read cycle did not finish in three edges.");

	read_data_a: assert property (
		readDone |=> (r.nvmData == $past(port.rdata)))
		else $error("Read byte not placed in data register.");

	ctrl_upper_zero_a: assert property (
		ctrlRead |=> (r.cpuRdata[7:4] == 4'h0))
		else $error("Control upper bits read nonzero.");

	prog_flags_a: assert property (
		progDone |=> (r.nvmIrqFlag && r.mfIrqFlag && !r.progTrig &&
			r.memWr))
		else $error("Program end did not raise both flags.");

	irq_gate_a: assert property (
		r.irqReq |-> ($past(globalIrqEnable) && r.nvmIrqEn &&
			r.mfIrqEn && r.nvmIrqFlag && r.mfIrqFlag))
		else $error("Interrupt requested without all enables.");

	ack_clear_a: assert property (
		(irqAck && !progDone && !irqWrite)
		|=> (!r.mfIrqFlag && r.nvmIrqFlag == $past(r.nvmIrqFlag)))
		else $error("Service cleared the wrong flag.");

	busy_ignore_a: assert property (
		(r.state != nvm_pkg::IDLE && !readDone && !progDone)
		|=> (r.state == $past(r.state) &&
			r.latchAddr == $past(r.latchAddr) &&
			r.latchData == $past(r.latchData)))
		else $error("Busy cycle disturbed by a new request.");

	bank_gate_a: assert property (
		(cpuWrite && cpuAddr == `ADDR_INDIRECT_ONE &&
			r.bankSel != `NVM_CTRL_BANK)
		|=> (r.progPerm == $past(r.progPerm) &&
			r.readPerm == $past(r.readPerm)))
		else $error("Control changed outside bank one.");

	prog_trig_hold_a: assert property (
		(r.state == nvm_pkg::PROG) |-> r.progTrig)
		else $error("Program trigger dropped while programming.");

	read_trig_hold_a: assert property (
		(r.state == nvm_pkg::READ) |-> r.readTrig)
		else $error("Read trigger dropped while reading.");

	idle_trig_low_a: assert property (
		(r.state == nvm_pkg::IDLE) |-> (!r.progTrig && !r.readTrig))
		else $error("Trigger bit left set while idle.");

	prog_start_a: assert property (
		startProg |=> (r.state == nvm_pkg::PROG && r.progTrig &&
			r.latchAddr == $past(r.nvmAddr) &&
			r.latchData == $past(r.nvmData)))
		else $error("Program did not start from the latched byte.");

	read_start_a: assert property (
		startRead |=> (r.state == nvm_pkg::READ && r.readTrig &&
			r.memRd && r.latchAddr == $past(r.nvmAddr)))
		else $error("Read did not start from the latched address.");

	prog_perm_need_a: assert property (
		(r.state == nvm_pkg::PROG && $past(r.state) == nvm_pkg::IDLE)
		|-> $past(r.progPerm))
		else $error("Program entered without prior permission.");

	read_perm_need_a: assert property (
		(r.state == nvm_pkg::READ && $past(r.state) == nvm_pkg::IDLE)
		|-> $past(r.readPerm))
		else $error("Read entered without prior permission.");

	perm_hold_a: assert property (
		!ctrlWrite |=> (r.progPerm == $past(r.progPerm) &&
			r.readPerm == $past(r.readPerm)))
		else $error("Permission changed without a control write.");

	data_hold_a: assert property (
		(!readDone && !(cpuWrite && cpuAddr == `ADDR_NVM_DATA))
		|=> $stable(r.nvmData))
		else $error("Data register changed with no read or write.");

	window_gate_a: assert property (
		(cpuRead && cpuAddr == `ADDR_INDIRECT_ONE && !ctrlSelected)
		|=> (r.cpuRdata == 8'h00))
		else $error("Control register read outside its window.");

	prog_tick_end_a: assert property (
		(r.state == nvm_pkg::PROG && !progTick) |=>
			(r.state == nvm_pkg::PROG && r.progTrig))
		else $error("Program ended without a timer tick.");

	one_access_a: assert property (
		!(r.memRd && r.memWr))
		else $error("Array read and written in one cycle.");

endmodule

// file: verif/cpu_model.sv
// Processor-side model: strobed register accesses and a free program timer.
// Assumes the access block samples its strobes on the rising sys_clk edge.
`timescale 1ns/1ns
`include "nvm_access_map.svh"
module cpu_model (
	// Clock.
	input  wire logic       sys_clk,
	// Bus to the access block.
	output logic      [7:0] cpuAddr,
	output logic            cpuWrite,
	output logic            cpuRead,
	output logic      [7:0] cpuWdata,
	input  wire logic [7:0] cpuRdata,
	// Timer and interrupt lines.
	output logic            progTick,
	output logic            globalIrqEnable,
	output logic            irqAck
);
	logic [1:0] tickDiv = 2'h0;

	initial begin
		cpuAddr         = 8'h00;
		cpuWrite        = 1'b0;
		cpuRead         = 1'b0;
		cpuWdata        = 8'h00;
		progTick        = 1'b0;
		globalIrqEnable = 1'b0;
		irqAck          = 1'b0;
	end

	// The timer runs apart from bus traffic, so program length is not fixed.
	always @(negedge sys_clk) begin
		tickDiv  <= tickDiv + 2'h1;
		progTick <= (tickDiv == 2'h3);
	end

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(negedge sys_clk);
		cpuAddr  = addr;
		cpuWdata = data;
		cpuWrite = 1'b1;
		@(negedge sys_clk);
		cpuWrite = 1'b0;
		cpuWdata = ~data;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(negedge sys_clk);
		cpuAddr = addr;
		cpuRead = 1'b1;
		@(negedge sys_clk);
		cpuRead = 1'b0;
		data    = cpuRdata;
	endtask

	// The control register is only reached through the pointer in bank one.
	task automatic openCtrl();
		wr(`ADDR_POINTER_ONE, `NVM_CTRL_PTR);
		wr(`ADDR_BANK_SELECT, `NVM_CTRL_BANK);
	endtask

	task automatic setGlobal(input logic en);
		@(negedge sys_clk);
		globalIrqEnable = en;
	endtask

	task automatic ackPulse();
		@(negedge sys_clk);
		irqAck = 1'b1;
		@(negedge sys_clk);
		irqAck = 1'b0;
	endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the data EEPROM access block.
// Assumes the processor model drives every bus, timer and interrupt input at the falling edge.
`timescale 1ns/1ns
`include "nvm_access_map.svh"
module tb_top;
	logic       sys_clk;
	logic       sys_rst;
	logic [7:0] cpuAddr;
	logic       cpuWrite;
	logic       cpuRead;
	logic [7:0] cpuWdata;
	logic [7:0] cpuRdata;
	logic       progTick;
	logic       globalIrqEnable;
	logic       irqAck;
	logic       irqRequest;
	logic [7:0] rdVal;
	int         fails;
	int         checkCount;

	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;

	nvm_access u_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .cpuAddr(cpuAddr),
		.cpuWrite(cpuWrite), .cpuRead(cpuRead), .cpuWdata(cpuWdata),
		.cpuRdata(cpuRdata), .progTick(progTick),
		.globalIrqEnable(globalIrqEnable), .irqAck(irqAck),
		.irqRequest(irqRequest)
	);

	cpu_model u_cpu (
		.sys_clk(sys_clk), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
		.cpuRead(cpuRead), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
		.progTick(progTick), .globalIrqEnable(globalIrqEnable),
		.irqAck(irqAck)
	);

	task automatic tally_and_finish();
		if (fails == 0 && checkCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic regIs(input logic [7:0] addr, input logic [7:0] exp);
		u_cpu.rd(addr, rdVal);
		check(rdVal, exp);
	endtask

	task automatic ctrlWr(input logic [7:0] data);
		u_cpu.wr(`ADDR_INDIRECT_ONE, data);
	endtask

	// Polls the control register until the given trigger bit drops.
	task automatic waitClear(input int bitIdx);
		logic [7:0] v;
		for (int i = 0; i < 100; i++) begin
			u_cpu.rd(`ADDR_INDIRECT_ONE, v);
			if (v[bitIdx] === 1'b0) return;
		end
		fails++;
		$display("[FAIL] %0t trigger bit never cleared", $time);
		tally_and_finish();
	endtask

	task automatic irqIs(input logic exp);
		repeat (3) @(negedge sys_clk);
		check({7'h00, irqRequest}, {7'h00, exp});
	endtask

	task automatic testReset();
		regIs(`ADDR_BANK_SELECT, `BANK_SEL_RESET);
		regIs(`ADDR_INDIRECT_ONE, 8'h00);
		u_cpu.openCtrl();
		regIs(`ADDR_POINTER_ONE, `NVM_CTRL_PTR);
		regIs(`ADDR_INDIRECT_ONE, 8'h00);
	endtask

	// Software never sets both triggers or all four control bits at once.
	task automatic testRefuse();
		ctrlWr(8'h04);
		regIs(`ADDR_INDIRECT_ONE, 8'h00);
		ctrlWr(8'h01);
		regIs(`ADDR_INDIRECT_ONE, 8'h00);
		ctrlWr(8'h0C);
		regIs(`ADDR_INDIRECT_ONE, 8'h08);
		ctrlWr(8'h03);
		regIs(`ADDR_INDIRECT_ONE, 8'h02);
		ctrlWr(8'hFA);
		regIs(`ADDR_INDIRECT_ONE, 8'h0A);
	endtask

	task automatic testProgram();
		u_cpu.wr(`ADDR_IRQ_CTRL, 8'h05);
		u_cpu.wr(`ADDR_NVM_ADDRESS, 8'hFF);
		u_cpu.wr(`ADDR_NVM_DATA, 8'hA5);
		ctrlWr(8'h0E);
		u_cpu.wr(`ADDR_NVM_ADDRESS, 8'h00);
		ctrlWr(8'h0B);
		regIs(`ADDR_INDIRECT_ONE, 8'h0E);
		waitClear(`CTRL_PROG_TRIG);
		regIs(`ADDR_IRQ_CTRL, 8'h0F);
		irqIs(1'b0);
		u_cpu.setGlobal(1'b1);
		irqIs(1'b1);
		u_cpu.ackPulse();
		regIs(`ADDR_IRQ_CTRL, 8'h07);
		irqIs(1'b0);
		u_cpu.wr(`ADDR_IRQ_CTRL, 8'h05);
		regIs(`ADDR_IRQ_CTRL, 8'h05);
	endtask

	task automatic testRead();
		u_cpu.wr(`ADDR_NVM_ADDRESS, 8'hFF);
		u_cpu.wr(`ADDR_NVM_DATA, 8'h00);
		ctrlWr(8'h0B);
		waitClear(`CTRL_READ_TRIG);
		regIs(`ADDR_NVM_DATA, 8'hA5);
		regIs(`ADDR_NVM_DATA, 8'hA5);
		regIs(`ADDR_INDIRECT_ONE, 8'h0A);
		regIs(`ADDR_NVM_ADDRESS, 8'hFF);
	endtask

	// Bank zero hides the control register; a mid-run reset clears it.
	task automatic testPowerOn();
		u_cpu.wr(`ADDR_BANK_SELECT, 8'h00);
		regIs(`ADDR_INDIRECT_ONE, 8'h00);
		ctrlWr(8'h00);
		u_cpu.wr(`ADDR_BANK_SELECT, `NVM_CTRL_BANK);
		regIs(`ADDR_INDIRECT_ONE, 8'h0A);
		@(negedge sys_clk);
		sys_rst = 1'b1;
		repeat (4) @(negedge sys_clk);
		sys_rst = 1'b0;
		regIs(`ADDR_BANK_SELECT, `BANK_SEL_RESET);
		u_cpu.openCtrl();
		regIs(`ADDR_INDIRECT_ONE, 8'h00);
		ctrlWr(8'h04);
		regIs(`ADDR_INDIRECT_ONE, 8'h00);
	endtask

	initial begin
		fails      = 0;
		checkCount = 0;
		sys_rst    = 1'b1;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		testReset();
		testRefuse();
		testProgram();
		testRead();
		testPowerOn();
		tally_and_finish();
	end
endmodule
